// file: inc/phy_cfg_pkg.sv
package phy_cfg_pkg;

	// ==========================================================
	// Register indices and address width
	// ==========================================================
	localparam logic [11:0] IDX_STRAP_VIEW_A = 12'h467;
	localparam logic [11:0] IDX_STRAP_VIEW_B = 12'h468;
	localparam logic [11:0] IDX_IND_CFG = 12'h469;
	localparam logic [11:0] IDX_RX_MATCH_CFG = 12'h4A0;
	localparam int ADDR_W = 14;

	// ==========================================================
	// Strap view field positions
	// ==========================================================
	localparam int SA_RXD1_LSB = 14;
	localparam int SA_RXD0_LSB = 12;
	localparam int SA_COL_LSB = 10;
	localparam int SA_RXER_LSB = 8;
	localparam int SA_CRS_LSB = 6;
	localparam int SA_RXDV_LSB = 4;
	localparam int SA_IND0_LSB = 0;
	localparam int SB_RXD3_LSB = 2;
	localparam int SB_RXD2_LSB = 0;

	// ==========================================================
	// Strap mode codes and defaults
	// ==========================================================
	localparam logic [1:0] MODE1 = 2'h0;
	localparam logic [1:0] MODE4 = 2'h3;
	localparam logic [1:0] DEF_RXD1 = 2'h0;
	localparam logic [1:0] DEF_RXD0 = 2'h0;
	localparam logic [1:0] DEF_COL = 2'h3;
	localparam logic [1:0] DEF_RXER = 2'h3;
	localparam logic [1:0] DEF_CRS = 2'h3;
	localparam logic [1:0] DEF_RXDV = 2'h0;
	localparam logic [1:0] DEF_IND0 = 2'h3;
	localparam logic [1:0] DEF_RXD3 = 2'h0;
	localparam logic [1:0] DEF_RXD2 = 2'h0;

	// ==========================================================
	// Indicator configuration fields
	// ==========================================================
	localparam int IC_IND1_POL = 10;
	localparam int IC_IND1_VAL = 9;
	localparam int IC_IND1_EN = 8;
	localparam int IC_IND3_POL = 6;
	localparam int IC_IND3_VAL = 5;
	localparam int IC_IND3_EN = 4;
	localparam logic RST_IND3_POL = 1'b1;

	// ==========================================================
	// Receive match configuration fields
	// ==========================================================
	localparam int RM_ORDER_LSB = 14;
	localparam int RM_SFD_SEL = 13;
	localparam int RM_CRC_GATE = 12;
	localparam logic [1:0] RST_ORDER = 2'h0;
	localparam logic RST_SFD_SEL = 1'b0;
	localparam logic RST_CRC_GATE = 1'b1;
	localparam logic [7:0] SFD_NORMAL = 8'hD5;
	localparam logic [7:0] SFD_ALT = 8'h5D;
	localparam logic [1:0] ORD_NORMAL = 2'h0;
	localparam logic [1:0] ORD_BITREV = 2'h1;
	localparam logic [1:0] ORD_NIBSWAP = 2'h2;
	localparam logic [1:0] ORD_NIBBITREV = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_STRAP = 2'b01,
		ST_RUN = 2'b10
	} phase_e;

endpackage

// file: rtl/phy_strap_led_rxcfg_regs.sv
`timescale 1ns/1ps
// Function
// - Strap view A holds 2-bit latched modes for rx data 1, rx data 0, COL, RX_ER, CRS, RX_DV and indicator 0 at 15:14 down to 1:0.
// - Strap codes 00..11 mean modes 1..4 and are indices, with 01 and 10 reserved for indicator 0.
// - Strap view B holds rx data 3 mode at 3:2 and rx data 2 mode at 1:0, bits 15:4 reading zero.
// - Indicator 1 polarity bit 10 selects active high when set, resets to 0 and takes the pull level when straps are sampled.
// - Indicator 1 force enable bit 8 drives the pin to bit 9 instead of its normal function.
// - Indicator 3 force enable bit 4 drives the rx data 3 pin to bit 5, and polarity bit 6 resets to active high.
// - Order field 15:14 picks normal, bit reversed, nibble swapped or per-nibble bit reversed receive data.
// - Bit 13 selects a start delimiter of 0x5D when set and 0xD5 when clear, resetting to 0.
// - CRC gate bit 12, reset to 1, suppresses magic packet and pattern indications on bad CRC.
// - Strap defaults read 11 for COL, RX_ER, CRS and indicator 0 and 00 for rx data 1, rx data 0 and RX_DV.
module phy_strap_led_rxcfg_regs (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Strap inputs, valid while strap_sample is high
	input wire logic strap_sample,
	input wire logic [1:0] strap_rx_data1_pin,
	input wire logic [1:0] strap_rx_data0_pin,
	input wire logic [1:0] strap_col,
	input wire logic [1:0] strap_rx_er,
	input wire logic [1:0] strap_crs,
	input wire logic [1:0] strap_rx_dv,
	input wire logic [1:0] strap_indicator0_pin,
	input wire logic [1:0] strap_rx_data3_pin,
	input wire logic [1:0] strap_rx_data2_pin,
	input wire logic strap_indicator1_pull,
	// Indicator sources and pins
	input wire logic ind1_func,
	input wire logic ind3_func,
	output logic indicator1_pin,
	output logic indicator3_output,
	// Receive matcher
	input wire logic [7:0] rx_byte,
	input wire logic rx_byte_valid,
	input wire logic frame_crc_bad,
	input wire logic magic_hit,
	input wire logic pattern_hit,
	output logic [7:0] rx_byte_ordered,
	output logic sfd_found,
	output logic magic_ind,
	output logic pattern_ind
);

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed {
		phy_cfg_pkg::phase_e phase;
		logic [15:0] view_a;
		logic [15:0] view_b;
		logic ind1_pol;
		logic ind1_val;
		logic ind1_en;
		logic ind3_pol;
		logic ind3_val;
		logic ind3_en;
		logic [1:0] order;
		logic sfd_sel;
		logic crc_gate;
		logic dp_wr;
		logic [11:0] dp_idx;
		logic [31:0] rdata;
		logic [7:0] rx_ord;
		logic sfd_hit;
		logic magic;
		logic pattern;
		logic ind1;
		logic ind3;
	} state_s;

	state_s s_q;
	state_s s_d;

	function automatic logic [3:0] rev4(input logic [3:0] n);
		rev4 = {n[0], n[1], n[2], n[3]};
	endfunction

	function automatic logic [7:0] reorder(input logic [7:0] b, input logic [1:0] ord);
		case (ord)
			phy_cfg_pkg::ORD_NORMAL: reorder = b;
			phy_cfg_pkg::ORD_BITREV: reorder = {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
			phy_cfg_pkg::ORD_NIBSWAP: reorder = {b[3:0], b[7:4]};
			phy_cfg_pkg::ORD_NIBBITREV: reorder = {rev4(b[7:4]), rev4(b[3:0])};
			default: reorder = b;
		endcase
	endfunction

	function automatic logic [15:0] ind_word(input state_s s);
		ind_word = 16'h0000;
		ind_word[phy_cfg_pkg::IC_IND1_POL] = s.ind1_pol;
		ind_word[phy_cfg_pkg::IC_IND1_VAL] = s.ind1_val;
		ind_word[phy_cfg_pkg::IC_IND1_EN] = s.ind1_en;
		ind_word[phy_cfg_pkg::IC_IND3_POL] = s.ind3_pol;
		ind_word[phy_cfg_pkg::IC_IND3_VAL] = s.ind3_val;
		ind_word[phy_cfg_pkg::IC_IND3_EN] = s.ind3_en;
	endfunction

	logic addr_phase;
	logic [11:0] idx;
	logic [15:0] rd_word;
	logic [7:0] ord_byte;
	logic [7:0] sfd_want;

	assign addr_phase = hsel && hready && htrans[1];
	assign idx = haddr[phy_cfg_pkg::ADDR_W-1:2];

	// ==========================================================
	// Next-state logic
	// ==========================================================
	always_comb begin
		s_d = s_q;
		s_d.dp_wr = 1'b0;
		rd_word = 16'h0000;
		case (s_q.phase)
			phy_cfg_pkg::ST_IDLE: begin
				s_d.phase = phy_cfg_pkg::ST_STRAP;
			end
			phy_cfg_pkg::ST_STRAP: begin
				// Straps are caught once, at the second clock edge after reset release.
				if (strap_sample) begin
					s_d.view_a = 16'h0000;
					s_d.view_a[phy_cfg_pkg::SA_RXD1_LSB +: 2] = strap_rx_data1_pin;
					s_d.view_a[phy_cfg_pkg::SA_RXD0_LSB +: 2] = strap_rx_data0_pin;
					s_d.view_a[phy_cfg_pkg::SA_COL_LSB +: 2] = strap_col;
					s_d.view_a[phy_cfg_pkg::SA_RXER_LSB +: 2] = strap_rx_er;
					s_d.view_a[phy_cfg_pkg::SA_CRS_LSB +: 2] = strap_crs;
					s_d.view_a[phy_cfg_pkg::SA_RXDV_LSB +: 2] = strap_rx_dv;
					// Reserved indicator-0 codes fall back to mode 1.
					s_d.view_a[phy_cfg_pkg::SA_IND0_LSB +: 2] = (strap_indicator0_pin == phy_cfg_pkg::MODE4) ?
						phy_cfg_pkg::MODE4 : phy_cfg_pkg::MODE1;
					s_d.view_b = 16'h0000;
					s_d.view_b[phy_cfg_pkg::SB_RXD3_LSB +: 2] = strap_rx_data3_pin;
					s_d.view_b[phy_cfg_pkg::SB_RXD2_LSB +: 2] = strap_rx_data2_pin;
					s_d.ind1_pol = strap_indicator1_pull;
				end
				s_d.phase = phy_cfg_pkg::ST_RUN;
			end
			phy_cfg_pkg::ST_RUN: begin
				s_d.phase = phy_cfg_pkg::ST_RUN;
			end
			default: begin
				s_d.phase = phy_cfg_pkg::ST_IDLE;
			end
		endcase

		// Address phase capture.
		if (addr_phase) begin
			s_d.dp_wr = hwrite;
			s_d.dp_idx = idx;
		end

		// Write data phase; strap views have no write path.
		if (s_q.dp_wr) begin
			if (s_q.dp_idx == phy_cfg_pkg::IDX_IND_CFG) begin
				s_d.ind1_pol = hwdata[phy_cfg_pkg::IC_IND1_POL];
				s_d.ind1_val = hwdata[phy_cfg_pkg::IC_IND1_VAL];
				s_d.ind1_en = hwdata[phy_cfg_pkg::IC_IND1_EN];
				s_d.ind3_pol = hwdata[phy_cfg_pkg::IC_IND3_POL];
				s_d.ind3_val = hwdata[phy_cfg_pkg::IC_IND3_VAL];
				s_d.ind3_en = hwdata[phy_cfg_pkg::IC_IND3_EN];
			end else if (s_q.dp_idx == phy_cfg_pkg::IDX_RX_MATCH_CFG) begin
				s_d.order = hwdata[phy_cfg_pkg::RM_ORDER_LSB +: 2];
				s_d.sfd_sel = hwdata[phy_cfg_pkg::RM_SFD_SEL];
				s_d.crc_gate = hwdata[phy_cfg_pkg::RM_CRC_GATE];
			end
		end

		// Read data is registered at the end of the address phase.
		if (addr_phase && !hwrite) begin
			case (idx)
				phy_cfg_pkg::IDX_STRAP_VIEW_A: rd_word = s_q.view_a;
				phy_cfg_pkg::IDX_STRAP_VIEW_B: rd_word = s_q.view_b;
				phy_cfg_pkg::IDX_IND_CFG: rd_word = ind_word(s_q);
				phy_cfg_pkg::IDX_RX_MATCH_CFG: begin
					rd_word[phy_cfg_pkg::RM_ORDER_LSB +: 2] = s_q.order;
					rd_word[phy_cfg_pkg::RM_SFD_SEL] = s_q.sfd_sel;
					rd_word[phy_cfg_pkg::RM_CRC_GATE] = s_q.crc_gate;
				end
				default: rd_word = 16'h0000;
			endcase
			s_d.rdata = {16'h0000, rd_word};
		end

		// Indicator pins: forced level overrides polarity-adjusted function.
		s_d.ind1 = s_q.ind1_en ? s_q.ind1_val : (s_q.ind1_pol ? ind1_func : ~ind1_func);
		s_d.ind3 = s_q.ind3_en ? s_q.ind3_val : (s_q.ind3_pol ? ind3_func : ~ind3_func);

		// Receive matcher.
		ord_byte = reorder(rx_byte, s_q.order);
		sfd_want = s_q.sfd_sel ? phy_cfg_pkg::SFD_ALT : phy_cfg_pkg::SFD_NORMAL;
		s_d.rx_ord = rx_byte_valid ? ord_byte : s_q.rx_ord;
		s_d.sfd_hit = rx_byte_valid && (ord_byte == sfd_want);
		s_d.magic = magic_hit && !(s_q.crc_gate && frame_crc_bad);
		s_d.pattern = pattern_hit && !(s_q.crc_gate && frame_crc_bad);
	end

	// ==========================================================
	// Registers
	// ==========================================================
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			s_q.phase <= phy_cfg_pkg::ST_IDLE;
			s_q.view_a <= {phy_cfg_pkg::DEF_RXD1, phy_cfg_pkg::DEF_RXD0, phy_cfg_pkg::DEF_COL,
				phy_cfg_pkg::DEF_RXER, phy_cfg_pkg::DEF_CRS, phy_cfg_pkg::DEF_RXDV, 2'h0,
				phy_cfg_pkg::DEF_IND0};
			s_q.view_b <= {12'h000, phy_cfg_pkg::DEF_RXD3, phy_cfg_pkg::DEF_RXD2};
			s_q.ind3_pol <= phy_cfg_pkg::RST_IND3_POL;
			s_q.order <= phy_cfg_pkg::RST_ORDER;
			s_q.sfd_sel <= phy_cfg_pkg::RST_SFD_SEL;
			s_q.crc_gate <= phy_cfg_pkg::RST_CRC_GATE;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign hrdata = s_q.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign indicator1_pin = s_q.ind1;
	assign indicator3_output = s_q.ind3;
	assign rx_byte_ordered = s_q.rx_ord;
	assign sfd_found = s_q.sfd_hit;
	assign magic_ind = s_q.magic;
	assign pattern_ind = s_q.pattern;

endmodule // phy_strap_led_rxcfg_regs

// file: tb/phy_strap_led_rxcfg_regs_assertions.sv
`timescale 1ns/1ps
module phy_regs_chk (
	// Watched ports
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte_ordered,
	input wire logic sfd_found,
	input wire logic frame_crc_bad,
	input wire logic magic_hit,
	input wire logic pattern_hit,
	input wire logic magic_ind,
	input wire logic pattern_ind
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence clean(h);
		h && !frame_crc_bad;
	endsequence
	a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
	a_upper_zero: assert property (hrdata[31:16] == 16'h0000) else $error("upper read half not zero");
	a_magic_pass: assert property (clean(magic_hit) |=> magic_ind) else $error("clean magic hit lost");
	a_pattern_pass: assert property (clean(pattern_hit) |=> pattern_ind) else $error("clean pattern lost");
	a_magic_cause: assert property (magic_ind |-> $past(magic_hit)) else $error("magic without hit");
	a_pattern_cause: assert property (pattern_ind |-> $past(pattern_hit)) else $error("pattern without hit");
	a_sfd_cause: assert property (sfd_found |-> $past(rx_byte_valid)) else $error("delimiter without byte");
	a_order_hold: assert property (!rx_byte_valid |=> $stable(rx_byte_ordered)) else $error("byte moved");
endmodule // phy_regs_chk
bind phy_strap_led_rxcfg_regs phy_regs_chk u_chk (.*);

// file: tb/tb_phy_strap_led_rxcfg_regs.sv
`timescale 1ns/1ps
module tb_phy_strap_led_rxcfg_regs;
	logic clk_sys, rst, hsel, hwrite, hready, hreadyout, hresp, rd_pend, strap_sample, strap_indicator1_pull;
	logic ind1_func, ind3_func, indicator1_pin, indicator3_output, rx_byte_valid, sfd_found;
	logic frame_crc_bad, magic_hit, pattern_hit, magic_ind, pattern_ind;
	logic [31:0] haddr, hwdata, hrdata, seed, v;
	logic [1:0] htrans, strap_rx_data1_pin, strap_rx_data0_pin, strap_col, strap_rx_er, strap_crs;
	logic [1:0] strap_rx_dv, strap_indicator0_pin, strap_rx_data3_pin, strap_rx_data2_pin;
	logic [2:0] hsize;
	logic [7:0] rx_byte, rx_byte_ordered, b;
	logic [15:0] sa;
	int miscompares, check_count;
	logic [31:0] exp_q[$];
	logic [10:0] rx_q[$];
	logic [1:0] ind_q[$];
	logic [10:0] rx_e;
	logic [1:0] ind_e;
	logic rx_seen, ind_pend;
	assign hready = hreadyout;
	phy_strap_led_rxcfg_regs uut (.*);
	initial begin
		clk_sys = 0;
		forever #2 clk_sys = ~clk_sys;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] ord(input logic [7:0] d, input logic [1:0] o);
		case (o)
			2'h1: return {d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]};
			2'h2: return {d[3:0], d[7:4]};
			2'h3: return {d[4], d[5], d[6], d[7], d[0], d[1], d[2], d[3]};
			default: return d;
		endcase
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic test_done();
		if (miscompares == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (hready !== 1'b1 && n < 64);
		if (hready !== 1'b1) begin
			miscompares++;
			test_done();
		end
	endtask
	task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {18'h0, idx, 2'h0};
		wait_rdy();
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_pend <= !wr;
		wait_rdy();
		rd_pend <= 0;
	endtask
	task automatic rd(input logic [11:0] idx, input logic [31:0] e);
		exp_q.push_back(e);
		bus(0, idx, 32'h0);
	endtask
	task automatic send(input logic [7:0] d, input logic [7:0] e, input logic s, input logic [1:0] g);
		@(posedge clk_sys);
		rx_byte <= d;
		rx_byte_valid <= 1;
		magic_hit <= 1;
		pattern_hit <= 1;
		frame_crc_bad <= g[1];
		rx_q.push_back({e, s, !(g[0] && g[1]), !(g[0] && g[1])});
		@(posedge clk_sys);
		rx_byte_valid <= 0;
		magic_hit <= 0;
		pattern_hit <= 0;
	endtask
	always @(posedge clk_sys) begin
		if (rd_pend && hready)
			chk("hrdata", exp_q.pop_front(), hrdata);
	end
	// The receive results launched at the taking edge still stand when the next edge is sampled.
	always @(posedge clk_sys) begin
		rx_seen <= rx_byte_valid;
		if (rx_seen === 1'b1) begin
			rx_e = rx_q.pop_front();
			chk("ordered", {24'h0, rx_e[10:3]}, {24'h0, rx_byte_ordered});
			chk("sfd", {31'h0, rx_e[2]}, {31'h0, sfd_found});
			chk("magic", {31'h0, rx_e[1]}, {31'h0, magic_ind});
			chk("pattern", {31'h0, rx_e[0]}, {31'h0, pattern_ind});
		end
		if (ind_pend === 1'b1) begin
			ind_e = ind_q.pop_front();
			chk("indicator1", {31'h0, ind_e[1]}, {31'h0, indicator1_pin});
			chk("indicator3", {31'h0, ind_e[0]}, {31'h0, indicator3_output});
		end
	end
	initial begin
		seed = 36;
		rst = 1;
		hsize = 3'h2;
		strap_sample = 1;
		{hsel, hwrite, htrans, haddr, hwdata, rd_pend, ind1_func, ind3_func, rx_byte, rx_byte_valid} = '0;
		{frame_crc_bad, magic_hit, pattern_hit, ind_pend} = '0;
		{strap_rx_data1_pin, strap_rx_data0_pin, strap_col, strap_rx_er, strap_crs, strap_rx_dv,
			strap_indicator0_pin, strap_rx_data3_pin, strap_rx_data2_pin, strap_indicator1_pull} = 19'(xs());
		repeat (20) @(posedge clk_sys);
		rst <= 0;
		repeat (3) @(posedge clk_sys);
		sa = {strap_rx_data1_pin, strap_rx_data0_pin, strap_col, strap_rx_er, strap_crs, strap_rx_dv, 2'h0,
			(strap_indicator0_pin[0] ~^ strap_indicator0_pin[1]) ? strap_indicator0_pin : 2'h0};
		rd(phy_cfg_pkg::IDX_IND_CFG, {21'h0, strap_indicator1_pull, 3'h0, 1'b1, 6'h0});
		rd(phy_cfg_pkg::IDX_RX_MATCH_CFG, 32'h0000_1000);
		repeat (2) begin
			rd(phy_cfg_pkg::IDX_STRAP_VIEW_A, {16'h0, sa});
			rd(phy_cfg_pkg::IDX_STRAP_VIEW_B, {28'h0, strap_rx_data3_pin, strap_rx_data2_pin});
			bus(1, phy_cfg_pkg::IDX_STRAP_VIEW_A, 32'hFFFF_FFFF);
			bus(1, phy_cfg_pkg::IDX_STRAP_VIEW_B, 32'hFFFF_FFFF);
			bus(1, 12'h000, 32'hFFFF_FFFF);
		end
		rd(12'h000, 32'h0);
		bus(1, phy_cfg_pkg::IDX_IND_CFG, 32'hFFFF_FFFF);
		rd(phy_cfg_pkg::IDX_IND_CFG, 32'h0000_0770);
		repeat (12) begin
			v = xs();
			b = 8'(xs());
			bus(1, phy_cfg_pkg::IDX_IND_CFG, v);
			ind1_func <= b[0];
			ind3_func <= b[1];
			ind_q.push_back({(v[8] ? v[9] : (v[10] ~^ b[0])), (v[4] ? v[5] : (v[6] ~^ b[1]))});
			@(posedge clk_sys);
			ind_pend <= 1;
			@(posedge clk_sys);
			ind_pend <= 0;
		end
		for (int k = 0; k < 16; k++) begin
			bus(1, phy_cfg_pkg::IDX_RX_MATCH_CFG, {16'h0, 4'(k), 12'h0});
			b = k[1] ? 8'h5D : 8'hD5;
			v = xs();
			send(ord(b, 2'(k >> 2)), b, 1'b1, {v[8], k[0]});
			send(v[7:0], ord(v[7:0], 2'(k >> 2)), ord(v[7:0], 2'(k >> 2)) == b, {v[9], k[0]});
		end
		@(posedge clk_sys);
		strap_sample <= 0;
		rst <= 1;
		repeat (3) @(posedge clk_sys);
		rst <= 0;
		repeat (3) @(posedge clk_sys);
		rd(phy_cfg_pkg::IDX_STRAP_VIEW_A, 32'h0000_0FC3);
		rd(phy_cfg_pkg::IDX_STRAP_VIEW_B, 32'h0);
		rd(phy_cfg_pkg::IDX_IND_CFG, 32'h0000_0040);
		rd(phy_cfg_pkg::IDX_RX_MATCH_CFG, 32'h0000_1000);
		test_done();
	end
endmodule // tb_phy_strap_led_rxcfg_regs
